// [irq_route_consts.svh]
// Constants for the interrupt routing and non-maskable interrupt merge block.
`ifndef IRQ_ROUTE_CONSTS_SVH
`define IRQ_ROUTE_CONSTS_SVH

// ----------------------------------------
// I/O port addresses
// ----------------------------------------
`define IO_INDEX_PORT 10'h026
`define IO_DATA_PORT 10'h027
`define IO_PIC_PRI_LO 10'h020
`define IO_PIC_PRI_HI 10'h021
`define IO_PIC_SEC_LO 10'h0a0
`define IO_PIC_SEC_HI 10'h0a1

// ----------------------------------------
// Indexed register offsets
// ----------------------------------------
`define IDX_PIN_ROUTING 8'h0d
`define IDX_NMI_STATUS 8'h19
`define IDX_CS0_MODE 8'h20
`define IDX_CS1_MODE 8'h24
`define IDX_CS2_MODE 8'h28
`define IDX_PRI_SHADOW 8'h40
`define IDX_SEC_SHADOW 8'h41

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ROUTE_A_LSB 0
`define ROUTE_B_LSB 4
`define CS_NMI_EN_BIT 7
`define NMI_BIT_PMU 0
`define NMI_BIT_KBD 1
`define NMI_BIT_CS0 2
`define NMI_BIT_CS1 3
`define NMI_BIT_CS2 4
`define RESET_BYTE 8'h00
`define IRQ_TIMER0 0
`define IRQ_CASCADE 2
`define IRQ_RESERVED 8
`define IRQ_RTC 9
`define GPIO_SEL_W 4

`endif

// [irq_route_pkg.sv]
// Types shared by the interrupt routing block.
package irq_route_pkg;

    typedef logic [15:0] irq_vec_t;
    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WRITE,
        ACC_READ
    } io_access_e;

endpackage

// [irq_source_map.sv]
// Maps one routed source onto a one-hot set of permitted IRQ lines.
`timescale 1ns/1ps
`include "irq_route_consts.svh"

module irq_source_map
    import irq_route_pkg::*;
#(
    parameter logic [15:0] ALLOWED = 16'h0000
) (
    input wire logic [3:0] sel,
    input wire logic req,
    output irq_vec_t lines
);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // A select that names a line the source may not reach drives nothing.
    wire irq_vec_t oneHot = irq_vec_t'(16'h0001 << sel);
    wire irq_vec_t permitted = oneHot & ALLOWED;

    assign lines = req ? permitted : 16'h0000;

endmodule

// [irq_routing_and_nmi_merge.sv]
// Interrupt routing, OR gating and NMI merge with the indexed register port.
//
// Summary of operation
// - Each external pin is steered by the routing mode register to IRQ1..IRQ7.
// - External pin routing can never select IRQ2.
// - Up to seven general-purpose I/O interrupt inputs are mapped onto IRQ lines.
// - Sources sharing a line are combined with a logical OR.
// - IRQ0 is driven only by timer channel 0.
// - IRQ2 is the controller cascade and carries no routed source.
// - IRQ1 accepts either pin, the keyboard unit or a GPIO interrupt.
// - IRQ3 and IRQ4 accept either pin, serial port, GPIO or PC Card.
// - IRQ5 accepts pins, GPIO, PC Card; IRQ6 only pins or GPIO.
// - IRQ7 accepts either pin, serial port, GPIO or PC Card.
// - IRQ9 is the RTC alarm, optionally ORed with a GPIO interrupt.
// - IRQ10-12,14,15 accept GPIO or PC Card; IRQ13 only GPIO.
// - All subsystem NMI requests are ORed onto the CPU NMI input.
// - Each NMI source is maskable within its own unit.
// - NMI sources are power management, keyboard unit and chip selects.
// - NMI source status is readable at index 19h.
// - Each NMI is cleared by its originating unit's own method.
// - Timer channel 2 drives the speaker; channel 1 is unused.
// - Index port 026h selects a register, data port 027h accesses it.
// - Primary controller decodes 020h-021h, secondary 0a0h-0a1h.
`timescale 1ns/1ps
`include "irq_route_consts.svh"

module irq_routing_and_nmi_merge
    import irq_route_pkg::*;
#(
    parameter int GPIO_IRQS = 7
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] ioAddr,
    input wire logic ioWrStb,
    input wire logic ioRdStb,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    output logic priPicSel,
    output logic secPicSel,
    input wire logic extIrqPinA,
    input wire logic extIrqPinB,
    input wire logic [GPIO_IRQS-1:0] gpioIrq,
    input wire logic [GPIO_IRQS*4-1:0] gpioIrqSel,
    input wire logic timer0Out,
    input wire logic timer2Out,
    input wire logic kbdIrq,
    input wire logic serialIrq,
    input wire logic [3:0] serialIrqSel,
    input wire logic pcCardIrq,
    input wire logic [3:0] pcCardIrqSel,
    input wire logic rtcAlarmIrq,
    input wire logic pmuNmiReq,
    input wire logic kbdNmiReq,
    input wire logic [2:0] csNmiReq,
    input wire logic [7:0] priPicMask,
    input wire logic [7:0] secPicMask,
    output logic [15:0] irqLines,
    output logic cpuNmi,
    output logic speakerDrive,
    output logic [7:0] csMode0,
    output logic [7:0] csMode1,
    output logic [7:0] csMode2
);

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    // Only the two external pins come from outside the clock domain.
    // GPIO, timer and unit requests are produced on this clock and are used directly.
    logic [1:0] pinMeta_ff;
    logic [1:0] pinSync_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_ff <= 2'h0;
            pinSync_ff <= 2'h0;
        end else begin
            pinMeta_ff <= {extIrqPinB, extIrqPinA};
            pinSync_ff <= pinMeta_ff;
        end
    end

    // ----------------------------------------
    // Indexed register port
    // ----------------------------------------
    logic [7:0] index_ff;
    logic [7:0] pinRouting_ff;
    logic [7:0] cs0_ff;
    logic [7:0] cs1_ff;
    logic [7:0] cs2_ff;

    wire hitIndex = (ioAddr == `IO_INDEX_PORT);
    wire hitData = (ioAddr == `IO_DATA_PORT);
    // The index persists, so several data accesses may follow one index write.
    wire wrIndex = ioWrStb && hitIndex;
    wire wrData = ioWrStb && hitData;
    wire wrRouting = wrData && (index_ff == `IDX_PIN_ROUTING);
    wire wrCs0 = wrData && (index_ff == `IDX_CS0_MODE);
    wire wrCs1 = wrData && (index_ff == `IDX_CS1_MODE);
    wire wrCs2 = wrData && (index_ff == `IDX_CS2_MODE);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            index_ff <= `RESET_BYTE;
            pinRouting_ff <= `RESET_BYTE;
            cs0_ff <= `RESET_BYTE;
            cs1_ff <= `RESET_BYTE;
            cs2_ff <= `RESET_BYTE;
        end else begin
            if (wrIndex) begin
                index_ff <= ioWrData;
            end
            if (wrRouting) begin
                pinRouting_ff <= ioWrData;
            end
            if (wrCs0) begin
                cs0_ff <= ioWrData;
            end
            if (wrCs1) begin
                cs1_ff <= ioWrData;
            end
            if (wrCs2) begin
                cs2_ff <= ioWrData;
            end
        end
    end

    // ----------------------------------------
    // Source routing
    // ----------------------------------------
    // Permitted destination lines for each assignable source.
    // A select outside a source's set is dropped rather than sent elsewhere.
    localparam logic [15:0] PIN_OK = 16'h00fa;
    localparam logic [15:0] SERIAL_OK = 16'h0098;
    localparam logic [15:0] CARD_OK = 16'hdcb8;
    localparam logic [15:0] GPIO_OK = 16'hfefa;

    irq_vec_t pinALines;
    irq_vec_t pinBLines;
    irq_vec_t serialLines;
    irq_vec_t cardLines;
    irq_vec_t [GPIO_IRQS-1:0] gpioLines;

    irq_source_map #(.ALLOWED(PIN_OK)) u_mapPinA (
        .sel(pinRouting_ff[`ROUTE_A_LSB +: 4]),
        .req(pinSync_ff[0]),
        .lines(pinALines)
    );

    irq_source_map #(.ALLOWED(PIN_OK)) u_mapPinB (
        .sel(pinRouting_ff[`ROUTE_B_LSB +: 4]),
        .req(pinSync_ff[1]),
        .lines(pinBLines)
    );

    irq_source_map #(.ALLOWED(SERIAL_OK)) u_mapSerial (
        .sel(serialIrqSel),
        .req(serialIrq),
        .lines(serialLines)
    );

    irq_source_map #(.ALLOWED(CARD_OK)) u_mapCard (
        .sel(pcCardIrqSel),
        .req(pcCardIrq),
        .lines(cardLines)
    );

    genvar g;
    generate
        for (g = 0; g < GPIO_IRQS; g++) begin : gen_gpio
            irq_source_map #(.ALLOWED(GPIO_OK)) u_mapGpio (
                .sel(gpioIrqSel[g*`GPIO_SEL_W +: `GPIO_SEL_W]),
                .req(gpioIrq[g]),
                .lines(gpioLines[g])
            );
        end
    endgenerate

    // OR of every GPIO contribution, built as a chain of partial sums.
    irq_vec_t [GPIO_IRQS:0] gpioAcc;
    assign gpioAcc[0] = 16'h0000;
    generate
        for (g = 0; g < GPIO_IRQS; g++) begin : gen_gpio_or
            assign gpioAcc[g+1] = gpioAcc[g] | gpioLines[g];
        end
    endgenerate

    // Fixed sources: keyboard unit on IRQ1, RTC alarm on IRQ9.
    wire irq_vec_t fixedLines = {6'h00, rtcAlarmIrq, 7'h00, kbdIrq, 1'b0};

    // Sharing sources are ORed; no conflict check is made between them.
    wire irq_vec_t routedOr = pinALines | pinBLines | serialLines | cardLines
        | gpioAcc[GPIO_IRQS] | fixedLines;

    // The lines are registered below so that every output comes from a flip-flop.
    // Timer 0 owns IRQ0; cascade IRQ2 and reserved IRQ8 are forced low.
    logic [15:0] nxt_irqLines;
    always_comb begin
        nxt_irqLines = routedOr;
        nxt_irqLines[`IRQ_TIMER0] = timer0Out;
        nxt_irqLines[`IRQ_CASCADE] = 1'b0;
        nxt_irqLines[`IRQ_RESERVED] = 1'b0;
    end

    // ----------------------------------------
    // NMI merge
    // ----------------------------------------
    // Power and keyboard requests arrive already masked by their own units;
    // chip select requests are masked here by each chip select mode register.
    wire [2:0] csEnable = {cs2_ff[`CS_NMI_EN_BIT], cs1_ff[`CS_NMI_EN_BIT],
        cs0_ff[`CS_NMI_EN_BIT]};
    wire [2:0] csNmiLive = csNmiReq & csEnable;

    logic [7:0] nxt_nmiStatus;
    always_comb begin
        nxt_nmiStatus = `RESET_BYTE;
        nxt_nmiStatus[`NMI_BIT_PMU] = pmuNmiReq;
        nxt_nmiStatus[`NMI_BIT_KBD] = kbdNmiReq;
        nxt_nmiStatus[`NMI_BIT_CS0] = csNmiLive[0];
        nxt_nmiStatus[`NMI_BIT_CS1] = csNmiLive[1];
        nxt_nmiStatus[`NMI_BIT_CS2] = csNmiLive[2];
    end

    // Status follows the request levels, so a source clears it by its own
    // method simply by dropping its request.
    // A sticky status would keep reporting a request that its source has withdrawn.
    logic [7:0] nmiStatus_ff;
    logic cpuNmi_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nmiStatus_ff <= `RESET_BYTE;
            cpuNmi_ff <= 1'b0;
        end else begin
            nmiStatus_ff <= nxt_nmiStatus;
            cpuNmi_ff <= |nxt_nmiStatus;
        end
    end

    // ----------------------------------------
    // Read data and output registers
    // ----------------------------------------
    logic [7:0] nxt_dataRead;
    always_comb begin
        case (index_ff)
            `IDX_PIN_ROUTING: nxt_dataRead = pinRouting_ff;
            `IDX_NMI_STATUS: nxt_dataRead = nmiStatus_ff;
            `IDX_CS0_MODE: nxt_dataRead = cs0_ff;
            `IDX_CS1_MODE: nxt_dataRead = cs1_ff;
            `IDX_CS2_MODE: nxt_dataRead = cs2_ff;
            `IDX_PRI_SHADOW: nxt_dataRead = priPicMask;
            `IDX_SEC_SHADOW: nxt_dataRead = secPicMask;
            default: nxt_dataRead = `RESET_BYTE;
        endcase
    end

    // Read data stands for the one cycle after the strobe and is zero otherwise.
    wire [7:0] nxt_ioRdData = (ioRdStb && hitIndex) ? index_ff
        : (ioRdStb && hitData) ? nxt_dataRead : `RESET_BYTE;

    // The controller selects follow the address alone; the strobes qualify them outside.
    wire nxt_priSel = (ioAddr == `IO_PIC_PRI_LO) || (ioAddr == `IO_PIC_PRI_HI);
    wire nxt_secSel = (ioAddr == `IO_PIC_SEC_LO) || (ioAddr == `IO_PIC_SEC_HI);

    logic [7:0] ioRdData_ff;
    logic priSel_ff;
    logic secSel_ff;
    logic [15:0] irqLines_ff;
    logic speaker_ff;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ioRdData_ff <= `RESET_BYTE;
            priSel_ff <= 1'b0;
            secSel_ff <= 1'b0;
            irqLines_ff <= 16'h0000;
            speaker_ff <= 1'b0;
        end else begin
            ioRdData_ff <= nxt_ioRdData;
            priSel_ff <= nxt_priSel;
            secSel_ff <= nxt_secSel;
            irqLines_ff <= nxt_irqLines;
            speaker_ff <= timer2Out;
        end
    end

    assign ioRdData = ioRdData_ff;
    assign priPicSel = priSel_ff;
    assign secPicSel = secSel_ff;
    assign irqLines = irqLines_ff;
    assign cpuNmi = cpuNmi_ff;
    assign speakerDrive = speaker_ff;
    assign csMode0 = cs0_ff;
    assign csMode1 = cs1_ff;
    assign csMode2 = cs2_ff;

endmodule

// [irq_route_props.sv]
// Checker for the interrupt routing and NMI merge block.
`timescale 1ns/1ps
module irq_route_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] ioAddr,
    input wire logic ioWrStb,
    input wire logic ioRdStb,
    input wire logic [7:0] ioRdData,
    input wire logic priPicSel,
    input wire logic secPicSel,
    input wire logic timer0Out,
    input wire logic timer2Out,
    input wire logic pmuNmiReq,
    input wire logic kbdNmiReq,
    input wire logic [2:0] csNmiReq,
    input wire logic [15:0] irqLines,
    input wire logic cpuNmi,
    input wire logic speakerDrive,
    input wire logic [7:0] csMode0,
    input wire logic [7:0] csMode1,
    input wire logic [7:0] csMode2
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_timer_line: assert property ($past(rst_n) |->
        irqLines[0] == $past(timer0Out))
        else $error("line 0 does not follow timer 0");
    a_fixed_idle: assert property (
        irqLines[2] == 1'b0 && irqLines[8] == 1'b0)
        else $error("cascade or reserved line driven");
    a_nmi_merge: assert property ($past(rst_n) |-> cpuNmi ==
        $past(pmuNmiReq | kbdNmiReq | (|(csNmiReq & {csMode2[7], csMode1[7], csMode0[7]}))))
        else $error("nmi output not the merge of enabled requests");
    a_read_idle: assert property (!$past(ioRdStb) |-> ioRdData == 8'h00)
        else $error("read data not zero outside a read");
    a_pri_decode: assert property ($past(rst_n) |->
        priPicSel == ($past(ioAddr) inside {10'h020, 10'h021}))
        else $error("primary select wrong");
    a_sec_decode: assert property ($past(rst_n) |->
        secPicSel == ($past(ioAddr) inside {10'h0a0, 10'h0a1}))
        else $error("secondary select wrong");
    a_speaker_copy: assert property ($past(rst_n) |->
        speakerDrive == $past(timer2Out))
        else $error("speaker does not follow timer 2");
    a_mode_hold: assert property ($past(rst_n) && !$past(ioWrStb) |->
        $stable({csMode0, csMode1, csMode2})) else $error("mode register changed without write");
endmodule

bind irq_routing_and_nmi_merge irq_route_props irq_route_props_i (
    .mclk(mclk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
    .ioRdData(ioRdData), .priPicSel(priPicSel), .secPicSel(secPicSel),
    .timer0Out(timer0Out), .timer2Out(timer2Out), .pmuNmiReq(pmuNmiReq),
    .kbdNmiReq(kbdNmiReq), .csNmiReq(csNmiReq), .irqLines(irqLines), .cpuNmi(cpuNmi),
    .speakerDrive(speakerDrive), .csMode0(csMode0), .csMode1(csMode1), .csMode2(csMode2)
);

// [cpu_irq_model.sv]
// Behavioural model of the processor interrupt and NMI inputs.
`timescale 1ns/1ps
module cpu_irq_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] irqLines,
    input wire logic cpuNmi,
    output int nmiCount,
    output logic [15:0] irqSeen
);
    logic nmiLast_ff;

    // Every line ever raised is recorded, so reserved lines can be checked at the end.

    // The NMI input is edge triggered, so only a rising edge is taken.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            nmiLast_ff <= 1'b0;
            nmiCount <= 0;
            irqSeen <= 16'h0000;
        end else begin
            nmiLast_ff <= cpuNmi;
            irqSeen <= irqSeen | irqLines;
            if (cpuNmi && !nmiLast_ff) begin
                nmiCount <= nmiCount + 1;
            end
        end
    end
endmodule

// [tb_irq_routing_and_nmi_merge.sv]
// Self-checking testbench for the interrupt routing and NMI merge block.
`timescale 1ns/1ps
module tb_irq_routing_and_nmi_merge;
    logic mclk = 1'b0;
    logic rst_n, ioWrStb, ioRdStb, extIrqPinA, extIrqPinB, timer0Out, timer2Out;
    logic kbdIrq, serialIrq, pcCardIrq, rtcAlarmIrq, pmuNmiReq, kbdNmiReq;
    logic priPicSel, secPicSel, cpuNmi, speakerDrive;
    logic [9:0] ioAddr;
    logic [7:0] ioWrData, ioRdData, priPicMask, secPicMask, csMode0, csMode1, csMode2;
    logic [6:0] gpioIrq;
    logic [27:0] gpioIrqSel;
    logic [3:0] serialIrqSel, pcCardIrqSel;
    logic [2:0] csNmiReq;
    logic [15:0] irqLines, irqSeen;
    int nmiCount, failures, cmp_count;
    localparam logic [15:0] PIN_OK = 16'h00fa;
    localparam logic [15:0] SRC_OK [3] = '{16'hfefa, 16'h0098, 16'hdcb8};

    irq_routing_and_nmi_merge irq_routing_and_nmi_merge_i (.mclk, .rst_n, .ioAddr, .ioWrStb,
        .ioRdStb, .ioWrData, .ioRdData, .priPicSel, .secPicSel, .extIrqPinA, .extIrqPinB,
        .gpioIrq, .gpioIrqSel, .timer0Out, .timer2Out, .kbdIrq, .serialIrq, .serialIrqSel,
        .pcCardIrq, .pcCardIrqSel, .rtcAlarmIrq, .pmuNmiReq, .kbdNmiReq, .csNmiReq,
        .priPicMask, .secPicMask, .irqLines, .cpuNmi, .speakerDrive, .csMode0, .csMode1,
        .csMode2);
    cpu_irq_model cpu_irq_model_i (.mclk, .rst_n, .irqLines, .cpuNmi, .nmiCount, .irqSeen);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge mclk);
        ioAddr = a;
        ioWrData = d;
        ioWrStb = 1'b1;
        @(negedge mclk);
        ioWrStb = 1'b0;
    endtask
    task automatic wri(input logic [7:0] i, input logic [7:0] d);
        wr(10'h026, i);
        wr(10'h027, d);
    endtask
    task automatic rdi(input logic [7:0] i, input logic [7:0] exp);
        wr(10'h026, i);
        @(negedge mclk);
        ioAddr = 10'h027;
        ioRdStb = 1'b1;
        @(negedge mclk);
        ioRdStb = 1'b0;
        chk(16'(ioRdData), 16'(exp));
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #20 mclk = ~mclk;
    end
    initial begin
        #200000;
        failures++;
        complete_run();
    end
    initial begin
        {rst_n, ioWrStb, ioRdStb, extIrqPinA, extIrqPinB, timer0Out, timer2Out} = '0;
        {kbdIrq, serialIrq, pcCardIrq, rtcAlarmIrq, pmuNmiReq, kbdNmiReq, csNmiReq} = '0;
        {ioAddr, ioWrData, gpioIrq, gpioIrqSel, serialIrqSel, pcCardIrqSel} = '0;
        priPicMask = 8'h5a;
        secPicMask = 8'ha5;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        rdi(8'h0d, 8'h00);
        rdi(8'h33, 8'h00);
        wri(8'h19, 8'hff);
        rdi(8'h19, 8'h00);
        rdi(8'h40, 8'h5a);
        rdi(8'h41, 8'ha5);
        wri(8'h24, 8'h3c);
        rdi(8'h24, 8'h3c);
        chk(16'(csMode1), 16'h3c);
        extIrqPinA = 1'b1;
        for (int n = 0; n < 16; n++) begin
            wri(8'h0d, 8'(n));
            repeat (3) @(negedge mclk);
            chk(irqLines, PIN_OK[n] ? 16'h1 << n : 16'h0);
        end
        wri(8'h0d, 8'h53);
        repeat (3) @(negedge mclk);
        chk(irqLines, 16'h0008);
        extIrqPinA = 1'b0;
        extIrqPinB = 1'b1;
        repeat (4) @(negedge mclk);
        chk(irqLines, 16'h0020);
        extIrqPinB = 1'b0;
        repeat (3) @(negedge mclk);
        chk(irqLines, 16'h0000);
        for (int s = 0; s < 3; s++) begin
            for (int n = 0; n < 16; n++) begin
                @(negedge mclk);
                gpioIrq = (s == 0) ? 7'h41 : 7'h00;
                serialIrq = (s == 1);
                pcCardIrq = (s == 2);
                gpioIrqSel = {7{4'(n)}};
                serialIrqSel = 4'(n);
                pcCardIrqSel = 4'(n);
                @(negedge mclk);
                chk(irqLines, SRC_OK[s][n] ? 16'h1 << n : 16'h0);
            end
        end
        {gpioIrq, serialIrq, serialIrqSel, pcCardIrq, pcCardIrqSel} = {7'h0, 1'b1, 4'h3, 1'b1, 4'h3};
        {timer0Out, kbdIrq, rtcAlarmIrq, timer2Out} = 4'hf;
        @(negedge mclk);
        chk(irqLines, 16'h020b);
        chk(16'(speakerDrive), 16'h1);
        serialIrq = 1'b0;
        @(negedge mclk);
        chk(irqLines, 16'h020b);
        csNmiReq = 3'b111;
        repeat (2) @(negedge mclk);
        chk(16'(cpuNmi), 16'h0);
        wri(8'h20, 8'h80);
        chk(16'(csMode0), 16'h80);
        wri(8'h28, 8'h80);
        rdi(8'h19, 8'h14);
        chk(16'(cpuNmi), 16'h1);
        {csNmiReq, pmuNmiReq, kbdNmiReq} = 5'b00011;
        rdi(8'h19, 8'h03);
        {pmuNmiReq, kbdNmiReq} = 2'b00;
        @(negedge mclk);
        chk(16'(cpuNmi), 16'h0);
        chk(16'(nmiCount), 16'h1);
        chk(irqSeen, 16'hfefb);
        ioAddr = 10'h0a1;
        @(negedge mclk);
        chk(16'({priPicSel, secPicSel}), 16'h1);
        ioAddr = 10'h020;
        @(negedge mclk);
        chk(16'({priPicSel, secPicSel}), 16'h2);
        rst_n = 1'b0;
        @(negedge mclk);
        chk(16'(csMode2), 16'h0);
        rst_n = 1'b1;
        rdi(8'h20, 8'h00);
        complete_run();
    end
endmodule
